// ===== charger_regs_defines.svh
// Register offsets, field positions, reset values and timing for the
// charger control register bank. Definitions only.
`ifndef CHARGER_REGS_DEFINES_SVH
`define CHARGER_REGS_DEFINES_SVH

// ****************************************
// Offsets
// ****************************************
`define CC_ADDR_CTRL_STATUS 8'h00
`define CC_ADDR_CTRL_CONFIG 8'h01
`define CC_ADDR_FLOAT 8'h02
`define CC_ADDR_IDENT 8'h03
`define CC_ADDR_IDENT_ALT 8'h3B
`define CC_ADDR_CURRENT 8'h04
`define CC_ADDR_LIMITED 8'h05
`define CC_ADDR_SAFETY 8'h06
`define CC_ADDR_MONITOR 8'h10

// ****************************************
// Reset values
// ****************************************
`define CC_RST_IND_ENABLE 1'h1
`define CC_RST_CTRL_CONFIG 8'h30
`define CC_RST_FLOAT 8'h08
`define CC_RST_CURRENT 8'h09
`define CC_RST_LIMITED 8'h04
`define CC_RST_SAFETY 8'h40

// ****************************************
// Field positions and codes
// ****************************************
`define CC_BIT_COMMAND 7
`define CC_BIT_THERMAL 4
`define CC_STATE_CHARGING 2'h1
`define CC_STATE_FAULT 2'h3
`define CC_ZERO_BYTE 8'h00

// ****************************************
// Timing
// ****************************************
`define CC_CLK_PERIOD_NS 25
`define CC_BLINK_HALF_NS 1000000

`endif

// ===== charger_regs_pkg.sv
// Types shared by the charger control register bank.
// Assumes the analog side delivers its flags already synchronous.
package charger_regs_pkg;

    typedef enum logic [1:0] {
        SENSE_FIELD,
        SENSE_FIXED_34MV,
        SENSE_THERMAL_22MV
    } sense_mode_t;

    typedef struct packed {
        logic host_mode_pin;
        logic [1:0] charge_state;
        logic boost_active;
        logic [2:0] fault_code;
        logic limited_source_found;
        logic disable_pin;
        logic thermal_high;
        logic [7:0] monitor;
    } status_in_t;

    typedef struct packed {
        logic [1:0] input_current_cap;
        logic [1:0] weak_battery_level;
        logic charge_cutoff_allow;
        logic charger_off;
        logic high_impedance_select;
        logic boost_request;
        logic [5:0] float_voltage;
        logic [2:0] fast_charge_current;
        logic [2:0] end_current_level;
        logic aux_regulator_off;
        logic [2:0] limited_source_hold_voltage;
        sense_mode_t sense_mode;
    } config_out_t;

endpackage : charger_regs_pkg

// ===== charger_control_register_bank.sv
// Control and status register bank of a single-cell charger.
// Assumes a serial protocol engine in front that issues one-cycle
// read and write strobes with an 8-bit register address.
//
// Function
// - Control bit 7 written one kicks the safety timer; zero is ignored.
// - Reading control bit 7 returns the host-mode pin level.
// - Indicator low while charging only if enabled; faults still pulse it.
// - Control bit 3 reads one while in boost mode.
// - Control bits 2:0 report the mode-dependent fault code.
// - Config bits 7:6 are the read-write input current cap.
// - Config bits 5:4 select the weak battery level 3.4 to 3.7 V.
// - Config bit 3 allows termination on minimum current.
// - Config bit 1 set selects high-impedance mode.
// - Float voltage bits 7:2 in 20 mV steps, default 000010.
// - Identification is read-only: supplier, part and revision codes.
// - Current bit 7 written one restores defaults but safety; reads one.
// - Current bits 6:4 select the fast-charge current.
// - Current bits 2:0 select end current; bit 3 reads one.
// - Limited-source bit 6 set switches the auxiliary regulator off.
// - Limited-source bit 5 set fixes the sense target at 34 mV unless the thermal limit applies.
// - Limited-source bit 4 reads the limited-source detection flag.
// - Limited-source bits 2:0 select the input hold voltage.
// - Safety bits 6:4 cap the fast-charge current used.
// - Safety bits 3:0 cap the float voltage used; bit 7 reads zero.
// - Monitor bit 4 is thermal; alone it limits sense to 22.1 mV.
// - Monitor bit 0 is the float loop, bit 1 the input supply flag.
// - Monitor bits are live, without debouncing.
`timescale 1ns/1ps
`include "charger_regs_defines.svh"

module charger_control_register_bank
    import charger_regs_pkg::*;
#(
    parameter int BLINK_CYCLES = `CC_BLINK_HALF_NS / `CC_CLK_PERIOD_NS,
    parameter logic [2:0] SUPPLIER_CODE = 3'h2,
    parameter logic [2:0] PART_CODE = 3'h3,
    parameter logic [1:0] STEP_CODE = 2'h1
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire status_in_t status_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic safety_timer_kick_o,
    output config_out_t config_o,
    output logic [2:0] current_used_o,
    output logic [5:0] float_used_o,
    output logic indicator_out_o,
    output logic indicator_oe_n_o
);
    // Supplier, part and step codes are arbitrary neutral values.

    // ****************************************
    // Address decode
    // ****************************************
    wire sel_ctrl0 = reg_addr_i == `CC_ADDR_CTRL_STATUS;
    wire sel_ctrl1 = reg_addr_i == `CC_ADDR_CTRL_CONFIG;
    wire sel_float = reg_addr_i == `CC_ADDR_FLOAT;
    wire sel_ident = (reg_addr_i == `CC_ADDR_IDENT)
                  || (reg_addr_i == `CC_ADDR_IDENT_ALT);
    wire sel_curr = reg_addr_i == `CC_ADDR_CURRENT;
    wire sel_limit = reg_addr_i == `CC_ADDR_LIMITED;
    wire sel_safety = reg_addr_i == `CC_ADDR_SAFETY;
    wire sel_mon = reg_addr_i == `CC_ADDR_MONITOR;

    wire cmd_bit = reg_wdata_i[`CC_BIT_COMMAND];
    wire wr_ctrl0 = reg_wr_i && sel_ctrl0;
    wire wr_ctrl1 = reg_wr_i && sel_ctrl1;
    wire wr_float = reg_wr_i && sel_float;
    wire wr_curr = reg_wr_i && sel_curr;
    wire wr_limit = reg_wr_i && sel_limit;
    wire wr_safety = reg_wr_i && sel_safety;
    // A defaults command wins over any field data in the same byte.
    wire param_reset = wr_curr && cmd_bit;

    // ****************************************
    // Storage
    // ****************************************
    logic ind_enable;
    logic [7:0] ctrl1;
    logic [7:0] float_reg;
    logic [5:0] curr_fields;
    logic [3:0] limit_fields;
    logic [6:0] safety_fields;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ind_enable <= `CC_RST_IND_ENABLE;
            ctrl1 <= `CC_RST_CTRL_CONFIG;
            float_reg <= `CC_RST_FLOAT;
        end else if (param_reset) begin
            ind_enable <= `CC_RST_IND_ENABLE;
            ctrl1 <= `CC_RST_CTRL_CONFIG;
            float_reg <= `CC_RST_FLOAT;
        end else begin
            if (wr_ctrl0) begin
                ind_enable <= reg_wdata_i[6];
            end
            if (wr_ctrl1) begin
                ctrl1 <= reg_wdata_i;
            end
            if (wr_float) begin
                float_reg <= reg_wdata_i;
            end
        end
    end

    localparam logic [7:0] CURR_RST = `CC_RST_CURRENT;
    localparam logic [7:0] LIMIT_RST = `CC_RST_LIMITED;
    localparam logic [7:0] SAFETY_RST = `CC_RST_SAFETY;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            curr_fields <= {CURR_RST[6:4], CURR_RST[2:0]};
            limit_fields <= {LIMIT_RST[6:5], LIMIT_RST[2:1]};
        end else if (param_reset) begin
            curr_fields <= {CURR_RST[6:4], CURR_RST[2:0]};
            limit_fields <= {LIMIT_RST[6:5], LIMIT_RST[2:1]};
        end else begin
            if (wr_curr) begin
                curr_fields <= {reg_wdata_i[6:4], reg_wdata_i[2:0]};
            end
            if (wr_limit) begin
                limit_fields <= {reg_wdata_i[6:5], reg_wdata_i[2:1]};
            end
        end
    end

    // The lowest hold-voltage bit is kept apart from its two upper bits in limit_fields.
    logic vsp_low;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vsp_low <= LIMIT_RST[0];
        end else if (param_reset) begin
            vsp_low <= LIMIT_RST[0];
        end else if (wr_limit) begin
            vsp_low <= reg_wdata_i[0];
        end
    end

    // The safety register is spared by the defaults command.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            safety_fields <= SAFETY_RST[6:0];
        end else if (wr_safety) begin
            safety_fields <= reg_wdata_i[6:0];
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    wire [7:0] rd_ctrl0 = {status_i.host_mode_pin,
                           ind_enable,
                           status_i.charge_state,
                           status_i.boost_active,
                           status_i.fault_code};
    wire [7:0] rd_ident = {SUPPLIER_CODE, PART_CODE, STEP_CODE};
    wire [7:0] rd_curr = {1'b1, curr_fields[5:3],
                          1'b1, curr_fields[2:0]};
    wire [7:0] rd_limit = {1'b0, limit_fields[3:2],
                           status_i.limited_source_found,
                           status_i.disable_pin,
                           limit_fields[1:0], vsp_low};
    wire [7:0] rd_safety = {1'b0, safety_fields};
    wire [7:0] rd_mon = status_i.monitor;

    wire [7:0] rd_mux = sel_ctrl0 ? rd_ctrl0
                      : sel_ctrl1 ? ctrl1
                      : sel_float ? float_reg
                      : sel_ident ? rd_ident
                      : sel_curr ? rd_curr
                      : sel_limit ? rd_limit
                      : sel_safety ? rd_safety
                      : sel_mon ? rd_mon
                      : `CC_ZERO_BYTE;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= `CC_ZERO_BYTE;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // ****************************************
    // Control outputs
    // ****************************************
    // The host pin only asks for boost while its gate bit is clear.
    wire pin_asks = !float_reg[0]
                 && (status_i.host_mode_pin == float_reg[1]);
    wire thermal_only = status_i.monitor[`CC_BIT_THERMAL]
                     && !status_i.thermal_high;
    wire [5:0] float_cap = {safety_fields[3:0], 2'b11};
    wire [2:0] req_current = curr_fields[5:3];
    wire [2:0] next_current = (req_current > safety_fields[6:4])
                            ? safety_fields[6:4] : req_current;
    wire [5:0] next_float = (float_reg[7:2] > float_cap)
                          ? float_cap : float_reg[7:2];
    sense_mode_t next_sense;
    assign next_sense = thermal_only ? SENSE_THERMAL_22MV
                      : limit_fields[2] ? SENSE_FIXED_34MV
                      : SENSE_FIELD;

    config_out_t next_config;
    always_comb begin
        next_config.input_current_cap = ctrl1[7:6];
        next_config.weak_battery_level = ctrl1[5:4];
        next_config.charge_cutoff_allow = ctrl1[3];
        next_config.charger_off = ctrl1[2];
        next_config.high_impedance_select = ctrl1[1];
        next_config.boost_request = ctrl1[0] || pin_asks;
        next_config.float_voltage = float_reg[7:2];
        next_config.fast_charge_current = req_current;
        next_config.end_current_level = curr_fields[2:0];
        next_config.aux_regulator_off = limit_fields[3];
        next_config.limited_source_hold_voltage =
            {limit_fields[1:0], vsp_low};
        next_config.sense_mode = next_sense;
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            config_o <= '0;
            current_used_o <= '0;
            float_used_o <= '0;
            safety_timer_kick_o <= 1'b0;
        end else begin
            config_o <= next_config;
            current_used_o <= next_current;
            float_used_o <= next_float;
            safety_timer_kick_o <= wr_ctrl0 && cmd_bit;
        end
    end

    // ****************************************
    // Charge indicator pin
    // ****************************************
    // A divider toggles the blink phase; a long period keeps the
    // fault pulses visible to a person, so sims should shorten it.
    logic [31:0] blink_count;
    logic blink_phase;
    wire blink_tick = blink_count == 32'(BLINK_CYCLES - 1);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            blink_count <= '0;
            blink_phase <= 1'b0;
        end else if (blink_tick) begin
            blink_count <= '0;
            blink_phase <= !blink_phase;
        end else begin
            blink_count <= blink_count + 32'h1;
        end
    end

    wire charging = status_i.charge_state == `CC_STATE_CHARGING;
    wire faulted = status_i.charge_state == `CC_STATE_FAULT;
    wire next_ind_low = (ind_enable && charging)
                     || (faulted && blink_phase);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            indicator_out_o <= 1'b0;
            indicator_oe_n_o <= 1'b1;
        end else begin
            indicator_out_o <= 1'b0;
            indicator_oe_n_o <= !next_ind_low;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence read_of(logic [7:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence

    timer_kick_a: assert property (
        reg_wr_i && reg_addr_i == `CC_ADDR_CTRL_STATUS
        |=> safety_timer_kick_o == $past(reg_wdata_i[7]))
        else $error("Timer kick does not follow the written bit.");

    status_read_a: assert property (
        read_of(`CC_ADDR_CTRL_STATUS)
        |=> reg_rvalid_o && reg_rdata_o[7] == $past(status_i.host_mode_pin)
            && reg_rdata_o[5:0] == $past(rd_ctrl0[5:0]))
        else $error("Status read does not show live state.");

    ind_charging_a: assert property (
        ind_enable && charging [*2] |-> !indicator_oe_n_o)
        else $error("Indicator not driven low while charging.");

    ind_quiet_a: assert property (
        !ind_enable && !faulted [*2] |-> indicator_oe_n_o)
        else $error("Indicator driven although disabled.");

    config_write_a: assert property (
        reg_wr_i && reg_addr_i == `CC_ADDR_CTRL_CONFIG
        ##1 !param_reset ##1 1
        |-> config_o.input_current_cap == $past(reg_wdata_i[7:6], 2)
            && config_o.charger_off == $past(reg_wdata_i[2], 2))
        else $error("Config write not reflected on outputs.");

    defaults_cmd_a: assert property (
        param_reset |=> ctrl1 == `CC_RST_CTRL_CONFIG
            && float_reg == `CC_RST_FLOAT
            && safety_fields == $past(safety_fields))
        else $error("Defaults command restored the wrong registers.");

    current_read_a: assert property (
        read_of(`CC_ADDR_CURRENT) |=> reg_rdata_o[7] && reg_rdata_o[3])
        else $error("Current register fixed bits wrong.");

    safety_read_a: assert property (
        read_of(`CC_ADDR_SAFETY) |=> !reg_rdata_o[7])
        else $error("Safety bit 7 read as one.");

    current_cap_a: assert property (
        ##1 current_used_o <= $past(safety_fields[6:4]))
        else $error("Used current above its ceiling.");

    thermal_sense_a: assert property (
        thermal_only |=> config_o.sense_mode == SENSE_THERMAL_22MV)
        else $error("Thermal limit not applied.");

    monitor_live_a: assert property (
        read_of(`CC_ADDR_MONITOR)
        |=> reg_rdata_o == $past(status_i.monitor))
        else $error("Monitor read is not the live value.");

endmodule : charger_control_register_bank

// ===== reg_host_model.sv
// Host-side model that issues register strobes to the charger bank.
// Assumes the bank takes a strobe on a rising edge and answers a read
// with a registered valid pulse one cycle later.
`timescale 1ns/1ps

module reg_host_model (
    input wire logic ref_clk_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    input wire logic kick_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // ****************************************
    // Bus cycles
    // ****************************************
    // Released address and data show the inverse of the last value, so a
    // design that samples them outside a strobe cannot pass by luck.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data,
                             output logic kick);
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b1;
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~data;
        #1;
        kick = kick_i;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                            output logic valid);
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= addr;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~addr;
        #1;
        valid = reg_rvalid_i;
        data = reg_rdata_i;
    endtask : read_reg
endmodule : reg_host_model

// ===== tb_charger_control_register_bank.sv
// Self-checking bench for the charger control register bank.
// Assumes the host model drives all strobes; the bench drives the flags.
`timescale 1ns/1ps

module tb_charger_control_register_bank;
    import charger_regs_pkg::*;
    localparam int BLINK = 4;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    status_in_t st = '0;
    logic wr, rd, rvalid, kick, out_pin, oe_n;
    logic [7:0] addr, wdata, rdata;
    config_out_t cfg;
    logic [2:0] cur_used;
    logic [5:0] flt_used;
    int n_errors = 0;
    int cmp_count = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    charger_control_register_bank #(.BLINK_CYCLES(BLINK)) dut_u (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .status_i(st), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .safety_timer_kick_o(kick), .config_o(cfg),
        .current_used_o(cur_used), .float_used_o(flt_used),
        .indicator_out_o(out_pin), .indicator_oe_n_o(oe_n));

    reg_host_model host_u (
        .ref_clk_i(ref_clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
        .reg_rvalid_i(rvalid), .kick_i(kick));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host_u.read_reg(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask : rd_chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic k;
        host_u.write_reg(a, d, k);
        check({7'h00, k}, {7'h00, a == 8'h00 && d[7]});
    endtask : wr_reg

    task automatic settle();
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask : settle

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_defaults();
        rd_chk(8'h01, 8'h30);
        rd_chk(8'h02, 8'h08);
        rd_chk(8'h04, 8'h89);
        rd_chk(8'h05, 8'h04);
        rd_chk(8'h06, 8'h40);
        rd_chk(8'h03, 8'h4D);
        rd_chk(8'h3B, 8'h4D);
        rd_chk(8'h07, 8'h00);
    endtask : s_defaults

    task automatic s_ctrl();
        st.host_mode_pin <= 1'b1;
        st.charge_state <= 2'h2;
        st.boost_active <= 1'b1;
        st.fault_code <= 3'h5;
        rd_chk(8'h00, 8'hED);
        wr_reg(8'h00, 8'h80);
        wr_reg(8'h00, 8'h40);
        st.host_mode_pin <= 1'b0;
        st.boost_active <= 1'b0;
        rd_chk(8'h00, 8'h65);
        wr_reg(8'h00, 8'h00);
        rd_chk(8'h00, 8'h25);
        wr_reg(8'h00, 8'h40);
    endtask : s_ctrl

    task automatic s_config();
        st.host_mode_pin <= 1'b1;
        wr_reg(8'h01, 8'hA5);
        rd_chk(8'h01, 8'hA5);
        settle();
        check({6'h00, cfg.input_current_cap}, 8'h02);
        check({6'h00, cfg.weak_battery_level}, 8'h02);
        check({6'h00, cfg.charge_cutoff_allow, cfg.charger_off},
              8'h01);
        check({6'h00, cfg.high_impedance_select, cfg.boost_request},
              8'h01);
        wr_reg(8'h01, 8'h5A);
        settle();
        check({cfg.input_current_cap, cfg.weak_battery_level,
               cfg.charge_cutoff_allow, cfg.charger_off,
               cfg.high_impedance_select, cfg.boost_request},
              8'h5A);
        wr_reg(8'h02, 8'h0A);
        settle();
        check({7'h00, cfg.boost_request}, 8'h01);
        wr_reg(8'h02, 8'h0B);
        settle();
        check({7'h00, cfg.boost_request}, 8'h00);
        check({2'h0, cfg.float_voltage}, 8'h02);
    endtask : s_config

    task automatic s_limits();
        wr_reg(8'h06, 8'hFF);
        rd_chk(8'h06, 8'h7F);
        wr_reg(8'h02, 8'hFE);
        wr_reg(8'h04, 8'h75);
        rd_chk(8'h04, 8'hFD);
        settle();
        check({2'h0, flt_used}, 8'h3F);
        check({5'h00, cur_used}, 8'h07);
        check({5'h00, cfg.end_current_level}, 8'h05);
        wr_reg(8'h06, 8'h30);
        settle();
        check({5'h00, cur_used}, 8'h03);
        check({2'h0, flt_used}, 8'h03);
        check({5'h00, cfg.fast_charge_current}, 8'h07);
        wr_reg(8'h04, 8'h80);
        rd_chk(8'h01, 8'h30);
        rd_chk(8'h02, 8'h08);
        rd_chk(8'h04, 8'h89);
        rd_chk(8'h06, 8'h30);
        settle();
        check({5'h00, cur_used}, 8'h00);
        check({2'h0, flt_used}, 8'h02);
        check({6'h00, cfg.sense_mode}, {6'h00, SENSE_FIELD});
    endtask : s_limits

    task automatic s_limited();
        st.limited_source_found <= 1'b1;
        st.disable_pin <= 1'b1;
        wr_reg(8'h05, 8'hE7);
        wr_reg(8'h03, 8'hFF);
        rd_chk(8'h03, 8'h4D);
        rd_chk(8'h05, 8'h7F);
        settle();
        check({6'h00, cfg.aux_regulator_off, 1'b0}, 8'h02);
        check({5'h00, cfg.limited_source_hold_voltage}, 8'h07);
        check({6'h00, cfg.sense_mode}, {6'h00, SENSE_FIXED_34MV});
        st.monitor <= 8'h10;
        settle();
        check({6'h00, cfg.sense_mode}, {6'h00, SENSE_THERMAL_22MV});
        st.thermal_high <= 1'b1;
        settle();
        check({6'h00, cfg.sense_mode}, {6'h00, SENSE_FIXED_34MV});
        st.monitor <= 8'hA5;
        rd_chk(8'h10, 8'hA5);
        st.monitor <= 8'h5A;
        rd_chk(8'h10, 8'h5A);
    endtask : s_limited

    task automatic s_indicator();
        int lows;
        lows = 0;
        st.charge_state <= 2'h1;
        settle();
        check({6'h00, oe_n, out_pin}, 8'h00);
        wr_reg(8'h00, 8'h00);
        settle();
        check({7'h00, oe_n}, 8'h01);
        st.charge_state <= 2'h3;
        settle();
        // Blink phase flips every BLINK cycles, so 4*BLINK cycles hold
        // exactly 2*BLINK driven-low cycles whatever the start phase.
        repeat (4 * BLINK) begin
            @(posedge ref_clk_i);
            #1;
            if (oe_n === 1'b0) lows++;
        end
        check(8'(lows), 8'(2 * BLINK));
    endtask : s_indicator

    // A reset in mid-run must restore the safety register as well.
    task automatic s_reset();
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(8'h06, 8'h40);
        rd_chk(8'h04, 8'h89);
        settle();
        check({2'h0, flt_used}, 8'h02);
    endtask : s_reset

    // ****************************************
    // Run control
    // ****************************************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        s_defaults();
        s_ctrl();
        s_config();
        s_limits();
        s_limited();
        s_indicator();
        s_reset();
        give_verdict();
    end

    // The tests need well under a thousand cycles; twenty times that is
    // a hang.
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_errors++;
        give_verdict();
    end
endmodule : tb_charger_control_register_bank
